// ==== spl_servo_input_limit.sv ====
// What this block does
// - speed agreement output is on while |measured - commanded| speed is below a 0..1000 setting, default 10.
// - a one-bit polarity setting, default 0, makes high (0) or low (1) on the sign input mean positive.
// - the pulse input has a digital noise filter set 0..15, default 4, longer with a larger value.
// - at the default pulse filter 500 kHz pulses pass, and each step up lowers the highest rate.
// - the sign input has its own filter set 0..15, default 1, behaving like the pulse filter.
// - a changed filter setting acts only after it is saved and the drive restarts.
// - with a limit input on, method 0 forces torque that way to zero and method 1 drops pulses that way.
// - second, third and fourth gear numerators are held, 0..32767, default 0.
//
// Purpose: conditions step and sign command inputs, limit switches and speed agreement
// Assumes: one 200 MHz clock; pins synchronised here; speeds in r/min from same-clock logic
// Notes: restart command stands for the save-and-power-cycle step of the filters
`timescale 1ns/100ps
`include "spl_defs.svh"
module spl_servo_input_limit
  import spl_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int FILT_CNT_W = 10
) (
  input wire logic i_clock, // 200 MHz system clock
  input wire logic i_sys_rst, // async reset, active high
  input wire logic i_clk_en, // freezes all state when low
  input wire logic [`SPL_ADDR_W-1:0] i_addr, // register byte address
  input wire logic [`SPL_DATA_W-1:0] i_wr_data, // register write data
  input wire logic i_wr_stb, // write strobe, one cycle
  input wire logic i_rd_stb, // read strobe, one cycle
  output logic [`SPL_DATA_W-1:0] o_rd_data, // read data, cycle after strobe
  input wire logic i_step_pulse_in, // command pulse pin
  input wire logic i_sign_in, // command direction pin
  input wire logic i_clockwise_limit_in, // clockwise limit switch, high = hit
  input wire logic i_counterclockwise_limit_in, // counter-clockwise limit, high = hit
  input wire logic signed [SPEED_W-1:0] i_measured_speed, // actual speed
  input wire logic signed [SPEED_W-1:0] i_commanded_speed, // commanded speed
  output logic o_speed_agreement_out, // speeds agree
  output logic o_cmd_step, // one accepted command pulse
  output logic o_cmd_dir_positive, // direction of command, high = positive
  output logic o_torque_block_cw, // force clockwise torque to zero
  output logic o_torque_block_ccw, // force counter-clockwise torque to zero
  output logic [15:0] o_gear_numerator_two, // second gear numerator
  output logic [15:0] o_gear_numerator_three, // third gear numerator
  output logic [15:0] o_gear_numerator_four // fourth gear numerator
);

  if (SPEED_W < 12 || SPEED_W > 31) begin : g_chk_speed
    $error("spl_servo_input_limit: SPEED_W must hold 1000 r/min and fit 32 bits");
  end

  function automatic logic hit(input logic [`SPL_ADDR_W-1:0] addr,
                               input logic [`SPL_ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [SPEED_W:0] abs_gap(input logic signed [SPEED_W-1:0] a,
                                               input logic signed [SPEED_W-1:0] b);
    logic signed [SPEED_W:0] d;
    d = {a[SPEED_W-1], a} - {b[SPEED_W-1], b};
    // extra bit: opposite full-scale speeds cannot wrap
    if (d[SPEED_W]) begin
      abs_gap = (SPEED_W+1)'(-d);
    end else begin
      abs_gap = d;
    end
  endfunction

  // saved settings, written by software
  spl_word_t speed_thr_reg;
  logic dir_pol_reg;
  spl_filt_t pulse_filt_reg;
  spl_filt_t sign_filt_reg;
  logic limit_method_reg;
  // settings in force, taken at boot or restart
  spl_filt_t pulse_filt_act_reg;
  spl_filt_t sign_filt_act_reg;

  spl_state_e state_reg;
  spl_state_e state_next;
  logic restart_req;
  logic load_now;

  logic [3:0] pin_sync;
  logic step_clean;
  logic sign_clean;
  logic cw_lim;
  logic ccw_lim;
  logic step_prev_reg;
  logic step_rise;
  logic dir_pos;
  logic blocked;

  spl_word_t drop_cnt_reg;
  logic [`SPL_DATA_W-1:0] rd_value;
  logic [`SPL_DATA_W-1:0] status_word;
  spl_word_t wr_word;

  assign wr_word = i_wr_data[15:0];
  assign restart_req = i_wr_stb && hit(i_addr, `SPL_OFS_CONTROL)
                       && i_wr_data[`SPL_CTRL_RESTART_BIT];

  // pins cross into the clock domain before any logic looks at them
  spl_sync2 #(
    .W(4)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async({
      i_counterclockwise_limit_in,
      i_clockwise_limit_in,
      i_sign_in,
      i_step_pulse_in
    }),
    .o_sync(pin_sync)
  );

  // limits skip the filter: a hit must act at once
  assign cw_lim = pin_sync[2];
  assign ccw_lim = pin_sync[3];

  spl_filt_if fif [2] ();
  logic [1:0] filt_clean;

  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_filt
    assign fif[gi].raw_lvl = pin_sync[gi];
    assign fif[gi].setting = (gi == 0) ? pulse_filt_act_reg : sign_filt_act_reg;
    assign fif[gi].flush = load_now;
    assign filt_clean[gi] = fif[gi].clean_lvl;
    spl_glitch_filter #(
      .CNT_W(FILT_CNT_W)
    ) u_filt (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .fif(fif[gi])
    );
  end

  assign step_clean = filt_clean[0];
  assign sign_clean = filt_clean[1];

  // restart sequencing: filter settings only change on these edges
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SPL_ST_BOOT: begin
        state_next = SPL_ST_RUN;
      end
      SPL_ST_RUN: begin
        if (restart_req) begin
          state_next = SPL_ST_FLUSH;
        end
      end
      SPL_ST_FLUSH: begin
        state_next = SPL_ST_RUN;
      end
      default: begin
        state_next = SPL_ST_BOOT;
      end
    endcase
  end

  assign load_now = (state_reg == SPL_ST_BOOT) || (state_reg == SPL_ST_FLUSH);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= SPL_ST_BOOT;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  // a write to the saved value alone does not reach the filters
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pulse_filt_act_reg <= `SPL_RST_PULSE_FILT;
      sign_filt_act_reg <= `SPL_RST_SIGN_FILT;
    end else if (i_clk_en && load_now) begin
      pulse_filt_act_reg <= pulse_filt_reg;
      sign_filt_act_reg <= sign_filt_reg;
    end
  end

  // speed threshold, clamped to its legal top
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      speed_thr_reg <= `SPL_RST_SPEED_THR;
    end else if (i_clk_en && i_wr_stb && hit(i_addr, `SPL_OFS_SPEED_THR)) begin
      speed_thr_reg <= (wr_word > `SPL_MAX_SPEED_THR) ? `SPL_MAX_SPEED_THR : wr_word;
    end
  end

  // gear numerators, top bit held at zero to keep 0..32767
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_gear_numerator_two <= `SPL_RST_GEAR;
      o_gear_numerator_three <= `SPL_RST_GEAR;
      o_gear_numerator_four <= `SPL_RST_GEAR;
    end else if (i_clk_en && i_wr_stb) begin
      if (hit(i_addr, `SPL_OFS_GEAR_TWO)) begin
        o_gear_numerator_two <= {1'b0, wr_word[`SPL_GEAR_W-1:0]};
      end
      if (hit(i_addr, `SPL_OFS_GEAR_THREE)) begin
        o_gear_numerator_three <= {1'b0, wr_word[`SPL_GEAR_W-1:0]};
      end
      if (hit(i_addr, `SPL_OFS_GEAR_FOUR)) begin
        o_gear_numerator_four <= {1'b0, wr_word[`SPL_GEAR_W-1:0]};
      end
    end
  end

  // polarity, filter and limit settings
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dir_pol_reg <= `SPL_RST_DIR_POL;
      pulse_filt_reg <= `SPL_RST_PULSE_FILT;
      sign_filt_reg <= `SPL_RST_SIGN_FILT;
      limit_method_reg <= `SPL_RST_LIMIT_METHOD;
    end else if (i_clk_en && i_wr_stb) begin
      if (hit(i_addr, `SPL_OFS_DIR_POL)) begin
        dir_pol_reg <= i_wr_data[0];
      end
      if (hit(i_addr, `SPL_OFS_PULSE_FILT)) begin
        pulse_filt_reg <= i_wr_data[3:0];
      end
      if (hit(i_addr, `SPL_OFS_SIGN_FILT)) begin
        sign_filt_reg <= i_wr_data[3:0];
      end
      if (hit(i_addr, `SPL_OFS_LIMIT_METHOD)) begin
        limit_method_reg <= i_wr_data[0];
      end
    end
  end

  // speed agreement: strict less-than, so a zero threshold never agrees
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_speed_agreement_out <= 1'b0;
    end else if (i_clk_en) begin
      o_speed_agreement_out <= abs_gap(i_measured_speed, i_commanded_speed)
                               < (SPEED_W+1)'(speed_thr_reg);
    end
  end

  // direction and pulse gating; clockwise taken as the positive direction
  assign dir_pos = sign_clean ^ dir_pol_reg;
  assign step_rise = step_clean && !step_prev_reg;
  assign blocked = limit_method_reg
                   && ((dir_pos && cw_lim) || (!dir_pos && ccw_lim));

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      step_prev_reg <= 1'b0;
      o_cmd_step <= 1'b0;
      o_cmd_dir_positive <= 1'b0;
    end else if (i_clk_en) begin
      // flush jumps the clean level; no false edge from it
      if (load_now) begin
        step_prev_reg <= pin_sync[0];
      end else begin
        step_prev_reg <= step_clean;
      end
      // pulses during boot or restart come from a half-flushed filter
      o_cmd_step <= step_rise && !blocked && (state_reg == SPL_ST_RUN);
      o_cmd_dir_positive <= dir_pos;
    end
  end

  // torque clamp for method 0
  // method 0 lets pulses on; the clamp holds the axis
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_torque_block_cw <= 1'b0;
      o_torque_block_ccw <= 1'b0;
    end else if (i_clk_en) begin
      o_torque_block_cw <= !limit_method_reg && cw_lim;
      o_torque_block_ccw <= !limit_method_reg && ccw_lim;
    end
  end

  // dropped-pulse count, saturating, cleared by restart
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      drop_cnt_reg <= '0;
    end else if (i_clk_en) begin
      if (load_now) begin
        drop_cnt_reg <= '0;
      end else if (step_rise && blocked && (drop_cnt_reg != 16'hffff)) begin
        drop_cnt_reg <= drop_cnt_reg + 16'h0001;
      end
    end
  end

  // shows filters in force, not the saved ones
  always_comb begin
    status_word = '0;
    status_word[`SPL_ST_PULSE_FILT_LSB +: 4] = pulse_filt_act_reg;
    status_word[`SPL_ST_SIGN_FILT_LSB +: 4] = sign_filt_act_reg;
    status_word[`SPL_ST_AGREE_BIT] = o_speed_agreement_out;
    status_word[`SPL_ST_CW_LIM_BIT] = cw_lim;
    status_word[`SPL_ST_CCW_LIM_BIT] = ccw_lim;
    status_word[`SPL_ST_DIR_POS_BIT] = dir_pos;
    status_word[`SPL_ST_RUN_BIT] = (state_reg == SPL_ST_RUN);
  end

  always_comb begin
    rd_value = '0;
    if (hit(i_addr, `SPL_OFS_SPEED_THR)) begin
      rd_value[15:0] = speed_thr_reg;
    end else if (hit(i_addr, `SPL_OFS_GEAR_TWO)) begin
      rd_value[15:0] = o_gear_numerator_two;
    end else if (hit(i_addr, `SPL_OFS_GEAR_THREE)) begin
      rd_value[15:0] = o_gear_numerator_three;
    end else if (hit(i_addr, `SPL_OFS_GEAR_FOUR)) begin
      rd_value[15:0] = o_gear_numerator_four;
    end else if (hit(i_addr, `SPL_OFS_DIR_POL)) begin
      rd_value[0] = dir_pol_reg;
    end else if (hit(i_addr, `SPL_OFS_PULSE_FILT)) begin
      rd_value[3:0] = pulse_filt_reg;
    end else if (hit(i_addr, `SPL_OFS_SIGN_FILT)) begin
      rd_value[3:0] = sign_filt_reg;
    end else if (hit(i_addr, `SPL_OFS_LIMIT_METHOD)) begin
      rd_value[0] = limit_method_reg;
    end else if (hit(i_addr, `SPL_OFS_STATUS)) begin
      rd_value = status_word;
    end else if (hit(i_addr, `SPL_OFS_DROP_COUNT)) begin
      rd_value[15:0] = drop_cnt_reg;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= '0;
    end else if (i_clk_en) begin
      o_rd_data <= i_rd_stb ? rd_value : '0;
    end
  end

endmodule // spl_servo_input_limit

// ==== spl_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts for the servo input block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: definitions only
`ifndef SPL_DEFS_SVH
`define SPL_DEFS_SVH

`define SPL_ADDR_W 8
`define SPL_DATA_W 32

`define SPL_OFS_SPEED_THR 8'h00
`define SPL_OFS_GEAR_TWO 8'h04
`define SPL_OFS_GEAR_THREE 8'h08
`define SPL_OFS_GEAR_FOUR 8'h0c
`define SPL_OFS_DIR_POL 8'h10
`define SPL_OFS_PULSE_FILT 8'h14
`define SPL_OFS_SIGN_FILT 8'h18
`define SPL_OFS_LIMIT_METHOD 8'h1c
`define SPL_OFS_CONTROL 8'h20
`define SPL_OFS_STATUS 8'h24
`define SPL_OFS_DROP_COUNT 8'h28

`define SPL_RST_SPEED_THR 16'h000a
`define SPL_MAX_SPEED_THR 16'h03e8
`define SPL_RST_GEAR 16'h0000
`define SPL_GEAR_W 15
`define SPL_RST_DIR_POL 1'h0
`define SPL_RST_PULSE_FILT 4'h4
`define SPL_RST_SIGN_FILT 4'h1
`define SPL_RST_LIMIT_METHOD 1'h0

`define SPL_CTRL_RESTART_BIT 0
`define SPL_ST_PULSE_FILT_LSB 0
`define SPL_ST_SIGN_FILT_LSB 4
`define SPL_ST_AGREE_BIT 8
`define SPL_ST_CW_LIM_BIT 9
`define SPL_ST_CCW_LIM_BIT 10
`define SPL_ST_DIR_POS_BIT 11
`define SPL_ST_RUN_BIT 12

`define SPL_CLK_PERIOD_NS 5
`define SPL_FILT_STEP_NS 250
`define SPL_FILT_STEP_CYC ((`SPL_FILT_STEP_NS + `SPL_CLK_PERIOD_NS - 1) / `SPL_CLK_PERIOD_NS)

`endif

// ==== spl_pkg.sv ====
// Purpose: shared types of the servo input block
// Assumes: constants live in spl_defs.svh
// Notes: state codes are one-hot
package spl_pkg;
  typedef logic [3:0] spl_filt_t;
  typedef logic [15:0] spl_word_t;
  typedef enum logic [2:0] {
    SPL_ST_BOOT = 3'b001,
    SPL_ST_RUN = 3'b010,
    SPL_ST_FLUSH = 3'b100
  } spl_state_e;
endpackage

// ==== spl_filt_if.sv ====
// Purpose: ties one input filter to the block top
// Assumes: single clock
// Notes: top drives raw level, setting and flush; filter drives clean level
`timescale 1ns/100ps
interface spl_filt_if;
  import spl_pkg::*;
  logic raw_lvl;
  spl_filt_t setting;
  logic flush;
  logic clean_lvl;
  modport owner (output raw_lvl, output setting, output flush, input clean_lvl);
  modport filter (input raw_lvl, input setting, input flush, output clean_lvl);
endinterface

// ==== spl_sync2.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: i_async may change at any time
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
module spl_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clock, // system clock
  input wire logic i_sys_rst, // async reset, high
  input wire logic i_clk_en, // freezes state when low
  input wire logic [W-1:0] i_async, // pin levels
  output logic [W-1:0] o_sync // synchronised levels
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else if (i_clk_en) begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // spl_sync2

// ==== spl_glitch_filter.sv ====
// Purpose: passes a level change only after it has held steady long enough
// Assumes: input already synchronised
// Notes: required hold is setting times one filter step
`timescale 1ns/100ps
`include "spl_defs.svh"
module spl_glitch_filter #(
  parameter int CNT_W = 10
) (
  input wire logic i_clock, // system clock
  input wire logic i_sys_rst, // async reset, high
  input wire logic i_clk_en, // freezes state when low
  spl_filt_if.filter fif // raw in, clean out
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] hold_cyc;
  logic [CNT_W:0] cnt_next;

  if (15 * `SPL_FILT_STEP_CYC >= (1 << CNT_W)) begin : g_chk
    $error("spl_glitch_filter: CNT_W too small for the longest hold");
  end

  // larger setting, longer hold, lower pulse rate that survives
  assign hold_cyc = CNT_W'(fif.setting) * CNT_W'(`SPL_FILT_STEP_CYC);
  assign cnt_next = {1'b0, cnt_reg} + (CNT_W+1)'(1);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
      fif.clean_lvl <= 1'b0;
    end else if (i_clk_en) begin
      if (fif.flush) begin
        cnt_reg <= '0;
        fif.clean_lvl <= fif.raw_lvl;
      end else if (fif.raw_lvl != fif.clean_lvl) begin
        if (cnt_next >= {1'b0, hold_cyc}) begin
          fif.clean_lvl <= fif.raw_lvl;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next[CNT_W-1:0];
        end
      end else begin
        cnt_reg <= '0; // any bounce restarts the hold
      end
    end
  end
endmodule // spl_glitch_filter

// ==== spl_servo_monitor.sv ====
// Purpose: port-level checks of the servo input block
// Assumes: one clock; i_clk_en high during checked traffic
// Notes: shadows rebuild threshold and limit method from bus writes
`timescale 1ns/100ps
`include "spl_defs.svh"
module spl_servo_monitor #(
  parameter int SPEED_W = 16,
  parameter int FILT_CNT_W = 10
) (
  input wire logic i_clock, // clock
  input wire logic i_sys_rst, // reset, high
  input wire logic i_clk_en, // clock enable
  input wire logic [`SPL_ADDR_W-1:0] i_addr, // address
  input wire logic [`SPL_DATA_W-1:0] i_wr_data, // write data
  input wire logic i_wr_stb, // write strobe
  input wire logic i_rd_stb, // read strobe
  input wire logic [`SPL_DATA_W-1:0] o_rd_data, // read data
  input wire logic i_step_pulse_in, // pulse pin
  input wire logic i_sign_in, // sign pin
  input wire logic i_clockwise_limit_in, // cw limit
  input wire logic i_counterclockwise_limit_in, // ccw limit
  input wire logic signed [SPEED_W-1:0] i_measured_speed, // actual speed
  input wire logic signed [SPEED_W-1:0] i_commanded_speed, // command speed
  input wire logic o_speed_agreement_out, // agreement
  input wire logic o_cmd_step, // step pulse
  input wire logic o_cmd_dir_positive, // direction
  input wire logic o_torque_block_cw, // cw torque block
  input wire logic o_torque_block_ccw, // ccw torque block
  input wire logic [15:0] o_gear_numerator_two, // gear two
  input wire logic [15:0] o_gear_numerator_three, // gear three
  input wire logic [15:0] o_gear_numerator_four // gear four
);
  logic [15:0] thr_q;
  logic meth_q;
  logic [2:0] rcnt;
  logic signed [SPEED_W:0] diff;
  logic [SPEED_W:0] absd;
  assign diff = i_measured_speed - i_commanded_speed;
  assign absd = diff[SPEED_W] ? $unsigned(-diff) : $unsigned(diff);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      thr_q <= `SPL_RST_SPEED_THR;
      meth_q <= `SPL_RST_LIMIT_METHOD;
    end else if (i_wr_stb && i_clk_en) begin
      if (i_addr == `SPL_OFS_SPEED_THR) begin
        thr_q <= (i_wr_data[15:0] > 16'h03e8) ? 16'h03e8 : i_wr_data[15:0];
      end
      if (i_addr == `SPL_OFS_LIMIT_METHOD) begin
        meth_q <= i_wr_data[0];
      end
    end
  end
  // edges since release; $past looks back into reset otherwise
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rcnt <= 3'h0;
    end else if (rcnt != 3'h7) begin
      rcnt <= rcnt + 3'h1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_speed_agree_level: assert property (rcnt != 3'h0 |-> o_speed_agreement_out ==
    ($past(absd) < {{(SPEED_W-15){1'b0}}, $past(thr_q)})) else $error("agreement level wrong");
  a_gear_write_takes: assert property (i_wr_stb && i_addr == `SPL_OFS_GEAR_TWO |=>
    o_gear_numerator_two[14:0] == $past(i_wr_data[14:0]) && !o_gear_numerator_two[15])
    else $error("gear two write lost");
  a_gear_hold_value: assert property (!(i_wr_stb && i_addr == `SPL_OFS_GEAR_TWO) |=>
    $stable(o_gear_numerator_two)) else $error("gear two changed unasked");
  a_rd_gear_echo: assert property (i_rd_stb && i_addr == `SPL_OFS_GEAR_TWO |=>
    o_rd_data == {16'h0, $past(o_gear_numerator_two)}) else $error("gear two readback wrong");
  a_rd_idle_zero: assert property (!i_rd_stb |=> o_rd_data == 32'h0)
    else $error("read data outside read cycle");
  a_torque_cw_block: assert property (rcnt > 3'h3 && meth_q == $past(meth_q, 3) |->
    o_torque_block_cw == ($past(i_clockwise_limit_in, 3) && !meth_q))
    else $error("cw torque block wrong");
  a_torque_ccw_block: assert property (rcnt > 3'h3 && meth_q == $past(meth_q, 3) |->
    o_torque_block_ccw == ($past(i_counterclockwise_limit_in, 3) && !meth_q))
    else $error("ccw torque block wrong");
  a_step_one_cycle: assert property (o_cmd_step |=> !o_cmd_step)
    else $error("step pulse too long");
  c_step: cover property (o_cmd_step);
  c_cw_block: cover property (o_torque_block_cw);
  c_agree_rise: cover property ($rose(o_speed_agreement_out));
endmodule // spl_servo_monitor

bind spl_servo_input_limit spl_servo_monitor #(.SPEED_W(SPEED_W), .FILT_CNT_W(FILT_CNT_W)) u_mon (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
  .i_step_pulse_in(i_step_pulse_in), .i_sign_in(i_sign_in),
  .i_clockwise_limit_in(i_clockwise_limit_in),
  .i_counterclockwise_limit_in(i_counterclockwise_limit_in),
  .i_measured_speed(i_measured_speed), .i_commanded_speed(i_commanded_speed),
  .o_speed_agreement_out(o_speed_agreement_out), .o_cmd_step(o_cmd_step),
  .o_cmd_dir_positive(o_cmd_dir_positive), .o_torque_block_cw(o_torque_block_cw),
  .o_torque_block_ccw(o_torque_block_ccw), .o_gear_numerator_two(o_gear_numerator_two),
  .o_gear_numerator_three(o_gear_numerator_three), .o_gear_numerator_four(o_gear_numerator_four));

// ==== spl_motion_ctrl_model.sv ====
// Purpose: motion controller driving pulse and sign pins
// Assumes: caller picks half periods; pins change just after an edge
// Notes: pulse pin rests low between bursts
`timescale 1ns/100ps
module spl_motion_ctrl_model (
  input wire logic i_clock, // system clock
  output logic o_step_pin, // pulse pin
  output logic o_sign_pin // sign pin
);
  initial begin
    o_step_pin = 1'b0;
    o_sign_pin = 1'b0;
  end
  task automatic send(input int n, input int half, input logic dir);
    @(posedge i_clock);
    o_sign_pin <= dir;
    // sign settles long before the first pulse so its filter has caught up
    repeat (100) @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      o_step_pin <= 1'b1;
      repeat (half) @(posedge i_clock);
      o_step_pin <= 1'b0;
      repeat (half) @(posedge i_clock);
    end
  endtask
endmodule // spl_motion_ctrl_model

// ==== spl_tb.sv ====
// Purpose: self-checking bench of the servo input block
// Assumes: 200 MHz clock; restart command stands for save and power cycle
// Notes: register rows first, then pulse, limit, speed and reset cases
`timescale 1ns/100ps
`include "spl_defs.svh"
module tb;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r0; logic [31:0] r1;} spl_row_s;
  logic i_clock, i_sys_rst, i_wr_stb, i_rd_stb, i_cw, i_ccw;
  logic [7:0] i_addr;
  logic [31:0] i_wr_data, o_rd_data, d, step_cnt = '0;
  logic signed [15:0] i_meas, i_cmd;
  logic o_agree, o_step, o_dir, o_tcw, o_tccw, step_pin, sign_pin;
  logic [15:0] o_g2, o_g3, o_g4;
  int miscompares = 0;
  int check_count = 0;
  spl_row_s rows [10] = '{
    '{`SPL_OFS_SPEED_THR, 32'h7d0, 32'ha, 32'h3e8},
    '{`SPL_OFS_GEAR_TWO, 32'hffffffff, 32'h0, 32'h7fff},
    '{`SPL_OFS_GEAR_THREE, 32'h1234, 32'h0, 32'h1234},
    '{`SPL_OFS_GEAR_FOUR, 32'h8001, 32'h0, 32'h1},
    '{`SPL_OFS_DIR_POL, 32'h3, 32'h0, 32'h1},
    '{`SPL_OFS_PULSE_FILT, 32'h1f, 32'h4, 32'hf},
    '{`SPL_OFS_SIGN_FILT, 32'h10, 32'h1, 32'h0},
    '{`SPL_OFS_LIMIT_METHOD, 32'h2, 32'h0, 32'h0},
    '{`SPL_OFS_STATUS, 32'hffff, 32'h1914, 32'h1914},
    '{8'h30, 32'hffffffff, 32'h0, 32'h0}};
  spl_servo_input_limit DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .o_rd_data(o_rd_data), .i_step_pulse_in(step_pin), .i_sign_in(sign_pin),
    .i_clockwise_limit_in(i_cw), .i_counterclockwise_limit_in(i_ccw),
    .i_measured_speed(i_meas), .i_commanded_speed(i_cmd), .o_speed_agreement_out(o_agree),
    .o_cmd_step(o_step), .o_cmd_dir_positive(o_dir), .o_torque_block_cw(o_tcw),
    .o_torque_block_ccw(o_tccw), .o_gear_numerator_two(o_g2),
    .o_gear_numerator_three(o_g3), .o_gear_numerator_four(o_g4));
  spl_motion_ctrl_model u_ctrl (.i_clock(i_clock), .o_step_pin(step_pin), .o_sign_pin(sign_pin));
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (o_step === 1'b1) step_cnt <= step_cnt + 32'h1;
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge i_clock);
    i_wr_stb <= 1'b1;
    i_addr <= a;
    i_wr_data <= w;
    @(posedge i_clock);
    i_wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_rd_stb <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd_stb <= 1'b0;
    #1 v = o_rd_data;
  endtask
  task automatic pulses(input int n, input int half, input logic dir, input logic [31:0] e);
    logic [31:0] s;
    s = step_cnt;
    u_ctrl.send(n, half, dir);
    // covers sync, the 200-cycle hold of filter setting 4 and the edge detect; the 750-cycle hold of setting 15 is longer
    repeat (300) @(posedge i_clock);
    chk("steps", e, step_cnt - s);
  endtask
  task automatic sp(input logic signed [15:0] m, input logic signed [15:0] c, input logic e);
    @(posedge i_clock);
    i_meas <= m;
    i_cmd <= c;
    repeat (3) @(posedge i_clock);
    chk("agree", {31'h0, e}, {31'h0, o_agree});
  endtask
  task automatic restart();
    wr(`SPL_OFS_CONTROL, 32'h1);
    repeat (3) @(posedge i_clock);
  endtask
  initial begin
    repeat (60000) @(posedge i_clock);
    miscompares++;
    results();
  end
  initial begin
    {i_sys_rst, i_wr_stb, i_rd_stb, i_cw, i_ccw} = 5'b10000;
    {i_addr, i_wr_data, i_meas, i_cmd} = '0;
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      chk("register before", rows[i].r0, d);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk("register after", rows[i].r1, d);
    end
    chk("gears", 32'h12340001, {o_g3, o_g4});
    $display("test registers done");
    // saved pulse filter is 15, active one still 4
    pulses(3, 200, 1'b1, 32'd3);
    pulses(3, 150, 1'b1, 32'd0);
    restart();
    rd(`SPL_OFS_STATUS, d);
    chk("active filters", 32'h0f, d & 32'hff);
    pulses(2, 400, 1'b1, 32'd0);
    wr(`SPL_OFS_PULSE_FILT, 32'h0);
    restart();
    pulses(4, 2, 1'b1, 32'd4);
    chk("dir", 32'h0, {31'h0, o_dir});
    wr(`SPL_OFS_DIR_POL, 32'h0);
    repeat (3) @(posedge i_clock);
    chk("dir", 32'h1, {31'h0, o_dir});
    $display("test filters done");
    i_cw <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk("torque cw", 32'h1, {31'h0, o_tcw});
    chk("torque ccw", 32'h0, {31'h0, o_tccw});
    wr(`SPL_OFS_LIMIT_METHOD, 32'h1);
    repeat (5) @(posedge i_clock);
    chk("torque cw", 32'h0, {31'h0, o_tcw});
    pulses(3, 2, 1'b1, 32'd0);
    rd(`SPL_OFS_DROP_COUNT, d);
    chk("dropped", 32'd3, d);
    pulses(3, 2, 1'b0, 32'd3);
    i_cw <= 1'b0;
    i_ccw <= 1'b1;
    wr(`SPL_OFS_LIMIT_METHOD, 32'h0);
    repeat (5) @(posedge i_clock);
    chk("torque ccw", 32'h1, {31'h0, o_tccw});
    $display("test limits done");
    wr(`SPL_OFS_SPEED_THR, 32'ha);
    sp(16'sd100, 16'sd91, 1'b1);
    sp(16'sd100, 16'sd90, 1'b0);
    sp(16'sd91, 16'sd100, 1'b1);
    sp(-16'sd5, 16'sd5, 1'b0);
    wr(`SPL_OFS_SPEED_THR, 32'h0);
    sp(16'sd3, 16'sd3, 1'b0);
    $display("test speed agreement done");
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk("gear two", 32'h0, {16'h0, o_g2});
    rd(`SPL_OFS_SPEED_THR, d);
    chk("threshold", 32'ha, d);
    $display("test reset done");
    results();
  end
endmodule // tb
